/* include/htd_pkg.sv */
// constants and types for the host transport dispatcher
package htd_pkg;

   // controller states
   typedef enum logic [3:0] {
      transport_idle_state    = 4'h0,
      rx_type_check_state     = 4'h1,
      command_frame_tx_state  = 4'h2,
      control_frame_tx_state  = 4'h3,
      dma_setup_tx_state      = 4'h4,
      selftest_tx_state       = 4'h5,
      pio_data_out_state      = 4'h6,
      register_frame_rx_state = 4'h7,
      device_bits_rx_state    = 4'h8,
      dma_activate_rx_state   = 4'h9,
      pio_setup_rx_state      = 4'hA,
      dma_setup_rx_state      = 4'hB,
      selftest_rx_state       = 4'hC,
      dma_data_in_state       = 4'hD,
      pio_data_in_state       = 4'hE
   } htd_state_t;

   // classes of incoming frame
   typedef enum logic [3:0] {
      htd_cls_register   = 4'h0,
      htd_cls_dev_bits   = 4'h1,
      htd_cls_dma_act    = 4'h2,
      htd_cls_pio_setup  = 4'h3,
      htd_cls_dma_setup  = 4'h4,
      htd_cls_selftest   = 4'h5,
      htd_cls_data       = 4'h6,
      htd_cls_unknown    = 4'h7
   } htd_class_t;

   // control-frame trigger options
   typedef enum logic [1:0] {
      htd_trig_soft_reset_bit_change  = 2'h0,
      htd_trig_every_write  = 2'h1,
      htd_trig_value_change = 2'h2
   } htd_trig_t;

   // frame type codes
   localparam logic [7:0] HTD_TYPE_REG_D2H = 8'h34;
   localparam logic [7:0] HTD_TYPE_REG_H2D = 8'h27;
   localparam logic [7:0] HTD_TYPE_DEV_BITS = 8'hA1;
   localparam logic [7:0] HTD_TYPE_DMA_ACT = 8'h39;
   localparam logic [7:0] HTD_TYPE_PIO_SETUP = 8'h5F;
   localparam logic [7:0] HTD_TYPE_DMA_SETUP = 8'h41;
   localparam logic [7:0] HTD_TYPE_SELFTEST = 8'h58;
   localparam logic [7:0] HTD_TYPE_DATA = 8'h46;

   // device control layout and reset values
   localparam int HTD_SOFT_RESET_BIT = 2;
   localparam logic [7:0] HTD_DEVCTL_RESET = 8'h00;

endpackage : htd_pkg

/* logic/htd_dispatch.sv */
// host transport dispatcher: idle event selection and frame type check
// Operation
// - idle waits for command write, control write or incoming frame
// - command register write in idle starts command frame transmit
// - control write toggling soft reset starts control frame transmit
// - option: control transmit on every write or on any value change
// - link frame arrival in idle enters the type check state
// - application dma setup request in idle starts dma setup transmit
// - application selftest request in idle starts selftest transmit
// - pending data writes after pio setup start pio data out
// - received pio setup sets a flag steering later data frames
// - type check decodes the type byte to choose the next state
// - register frame: report valid, enter register receive
// - set device bits frame: report valid, enter device bits receive
// - dma activate frame: report valid, enter dma activate handling
// - pio setup frame: report valid, enter pio setup receive
// - dma setup frame: report valid, enter dma setup receive
// - selftest activate frame: report valid, enter selftest receive
// - data frame without prior pio setup: valid, dma data in
// - data frame after pio setup: valid, pio data in
// - unknown frame type: report unrecognized, return to idle
// - illegal transition notice during type check returns to idle
// - register frames are never throttled by flow control
`timescale 1ns/100ps
module htd_dispatch
   import htd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cmd_wr,
   input wire logic devctl_wr,
   input wire logic [7:0] devctl_wdata,
   input wire htd_pkg::htd_trig_t ctl_trigger_mode,
   input wire logic link_rx_frame,
   input wire logic link_type_valid,
   input wire logic [7:0] link_rx_type,
   input wire logic link_illegal,
   input wire logic app_dma_setup_req,
   input wire logic app_selftest_req,
   input wire logic app_data_wr,
   input wire logic app_data_stall,
   input wire logic handler_done,
   output htd_pkg::htd_state_t state,
   output logic link_fis_ok,
   output logic link_fis_bad,
   output logic tx_throttle,
   output logic pio_setup_last,
   output logic [7:0] devctl_value
);
   import htd_pkg::*;

   htd_state_t state_q;
   htd_state_t state_d;
   htd_class_t rx_class;
   logic cmd_pend_q;
   logic ctl_pend_q;
   logic pio_pend_q;
   logic pio_last_q;
   logic [7:0] devctl_q;
   logic ctl_trigger;
   logic in_idle;
   logic in_check;
   logic take_frame;
   logic take_ctl;
   logic take_cmd;
   logic take_dma;
   logic take_bist;
   logic take_pio;
   logic check_decided;

   htd_type_decode u_decode
   (
      .fis_type(link_rx_type),
      .fis_class(rx_class)
   );

   assign in_idle = (state_q == transport_idle_state);
   assign in_check = (state_q == rx_type_check_state);

   // which writes count as a control-frame request
   always_comb
   begin
      unique case (ctl_trigger_mode)
         htd_trig_every_write: ctl_trigger = devctl_wr;
         htd_trig_value_change:
            ctl_trigger = devctl_wr && (devctl_wdata != devctl_q);
         default:
            ctl_trigger = devctl_wr &&
               (devctl_wdata[HTD_SOFT_RESET_BIT] !=
                devctl_q[HTD_SOFT_RESET_BIT]);
      endcase
   end

   // fixed priority among idle events
   always_comb
   begin
      take_frame = in_idle && link_rx_frame;
      take_ctl = in_idle && !take_frame && ctl_pend_q;
      take_cmd = in_idle && !take_frame && !ctl_pend_q &&
         cmd_pend_q;
      take_dma = in_idle && !link_rx_frame && !ctl_pend_q &&
         !cmd_pend_q && app_dma_setup_req;
      take_bist = in_idle && !link_rx_frame && !ctl_pend_q &&
         !cmd_pend_q && !app_dma_setup_req && app_selftest_req;
      take_pio = in_idle && !link_rx_frame && !ctl_pend_q &&
         !cmd_pend_q && !app_dma_setup_req && !app_selftest_req &&
         pio_pend_q && pio_last_q;
   end

   // shadow device control copy, the reference for change detection
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         devctl_q <= HTD_DEVCTL_RESET;
      else if (devctl_wr)
         devctl_q <= devctl_wdata;
   end

   // writes that arrive while busy are held until idle; a new write wins
   // over the clear so a back-to-back write is not lost
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cmd_pend_q <= 1'b0;
      else if (cmd_wr)
         cmd_pend_q <= 1'b1;
      else if (take_cmd)
         cmd_pend_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctl_pend_q <= 1'b0;
      else if (ctl_trigger)
         ctl_pend_q <= 1'b1;
      else if (take_ctl)
         ctl_pend_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pio_pend_q <= 1'b0;
      else if (app_data_wr)
         pio_pend_q <= 1'b1;
      else if (take_pio)
         pio_pend_q <= 1'b0;
   end

   assign check_decided = in_check && link_type_valid && !link_illegal;

   // remembers a received pio setup until another known non-data frame arrives or a pio data transfer ends
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pio_last_q <= 1'b0;
      else if (check_decided && rx_class == htd_cls_pio_setup)
         pio_last_q <= 1'b1;
      else if (check_decided && rx_class != htd_cls_data &&
               rx_class != htd_cls_unknown)
         pio_last_q <= 1'b0;
      else if (handler_done && (state_q == pio_data_in_state ||
               state_q == pio_data_out_state))
         pio_last_q <= 1'b0;
   end

   // next state
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         transport_idle_state:
         begin
            if (take_frame)
               state_d = rx_type_check_state;
            else if (take_ctl)
               state_d = control_frame_tx_state;
            else if (take_cmd)
               state_d = command_frame_tx_state;
            else if (take_dma)
               state_d = dma_setup_tx_state;
            else if (take_bist)
               state_d = selftest_tx_state;
            else if (take_pio)
               state_d = pio_data_out_state;
         end
         rx_type_check_state:
         begin
            if (link_illegal)
               state_d = transport_idle_state;
            else if (link_type_valid)
            begin
               unique case (rx_class)
                  htd_cls_register:
                     state_d = register_frame_rx_state;
                  htd_cls_dev_bits:
                     state_d = device_bits_rx_state;
                  htd_cls_dma_act:
                     state_d = dma_activate_rx_state;
                  htd_cls_pio_setup:
                     state_d = pio_setup_rx_state;
                  htd_cls_dma_setup:
                     state_d = dma_setup_rx_state;
                  htd_cls_selftest:
                     state_d = selftest_rx_state;
                  htd_cls_data:
                     state_d = pio_last_q ? pio_data_in_state
                                          : dma_data_in_state;
                  default:
                     state_d = transport_idle_state;
               endcase
            end
         end
         default:
         begin
            // handler states leave when their transaction ends
            if (handler_done || link_illegal)
               state_d = transport_idle_state;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_q <= transport_idle_state;
      else
         state_q <= state_d;
   end

   // link answers are combinational so they coincide with the decision
   always_comb
   begin
      link_fis_ok = check_decided &&
         rx_class != htd_cls_unknown;
      link_fis_bad = check_decided &&
         rx_class == htd_cls_unknown;
   end

   // only the pio data path may throttle; register frames never do
   assign tx_throttle = (state_q == pio_data_out_state) &&
      app_data_stall;

   assign state = state_q;
   assign pio_setup_last = pio_last_q;
   assign devctl_value = devctl_q;

   chk_reg_no_throttle: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == command_frame_tx_state ||
       state_q == control_frame_tx_state) |-> !tx_throttle)
      else $error("register frame throttled");

   chk_cmd_enters_tx: assert property (@(posedge clk) disable iff (sys_rst)
      (in_idle && cmd_pend_q && !link_rx_frame && !ctl_pend_q)
      |=> state_q == command_frame_tx_state)
      else $error("command write did not start command frame");

   chk_soft_reset_bit_toggle_ctl: assert property (@(posedge clk) disable iff (sys_rst)
      (ctl_trigger_mode == htd_trig_soft_reset_bit_change && devctl_wr &&
       devctl_wdata[HTD_SOFT_RESET_BIT] != devctl_q[HTD_SOFT_RESET_BIT])
      |=> ctl_pend_q || state_q == control_frame_tx_state)
      else $error("soft reset change not latched");

   chk_soft_reset_bit_same_none: assert property (@(posedge clk) disable iff (sys_rst)
      (ctl_trigger_mode == htd_trig_soft_reset_bit_change && devctl_wr &&
       devctl_wdata[HTD_SOFT_RESET_BIT] == devctl_q[HTD_SOFT_RESET_BIT] &&
       !ctl_pend_q) |=> !ctl_pend_q)
      else $error("control frame raised without soft reset change");

   chk_every_write_ctl: assert property (@(posedge clk) disable iff (sys_rst)
      (ctl_trigger_mode == htd_trig_every_write && devctl_wr)
      |=> ctl_pend_q || state_q == control_frame_tx_state)
      else $error("write did not request control frame");

   chk_frame_first: assert property (@(posedge clk) disable iff (sys_rst)
      (in_idle && link_rx_frame) |=> in_check)
      else $error("incoming frame not served first");

   chk_dma_tx: assert property (@(posedge clk) disable iff (sys_rst)
      (in_idle && !link_rx_frame && !ctl_pend_q && !cmd_pend_q &&
       app_dma_setup_req) |=> state_q == dma_setup_tx_state)
      else $error("dma setup request ignored");

   chk_bist_tx: assert property (@(posedge clk) disable iff (sys_rst)
      (take_bist) |=> state_q == selftest_tx_state)
      else $error("selftest request ignored");

   chk_pio_out_cause: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == pio_data_out_state && $past(in_idle))
      |-> $past(pio_last_q) && $past(pio_pend_q))
      else $error("pio data out without setup and data");

   chk_pio_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
      (check_decided && rx_class == htd_cls_pio_setup)
      ##1 (state_q == pio_setup_rx_state) |-> pio_last_q)
      else $error("pio setup flag not set");

   chk_data_route: assert property (@(posedge clk) disable iff (sys_rst)
      (check_decided && rx_class == htd_cls_data)
      |=> state_q == ($past(pio_last_q) ? pio_data_in_state
                                        : dma_data_in_state))
      else $error("data frame routed wrongly");

   chk_reg_route: assert property (@(posedge clk) disable iff (sys_rst)
      (check_decided && rx_class == htd_cls_register)
      |-> link_fis_ok ##1 state_q == register_frame_rx_state)
      else $error("register frame not accepted");

   chk_unknown_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (check_decided && rx_class == htd_cls_unknown)
      |-> link_fis_bad && !link_fis_ok ##1 in_idle)
      else $error("unknown frame not rejected");

   chk_illegal_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (in_check && link_illegal)
      |-> !link_fis_ok && !link_fis_bad ##1 in_idle)
      else $error("illegal transition not handled");

   chk_wait_check: assert property (@(posedge clk) disable iff (sys_rst)
      (in_check && !link_type_valid && !link_illegal) |=> in_check)
      else $error("type check left without a type");

   chk_bits_route: assert property (@(posedge clk) disable iff (sys_rst)
      (check_decided && rx_class == htd_cls_dev_bits)
      |-> link_fis_ok ##1 state_q == device_bits_rx_state)
      else $error("device bits frame not accepted");

   chk_act_route: assert property (@(posedge clk) disable iff (sys_rst)
      (check_decided && rx_class == htd_cls_dma_act)
      |-> link_fis_ok ##1 state_q == dma_activate_rx_state)
      else $error("dma activate frame not accepted");

   chk_dsetup_route: assert property (@(posedge clk) disable iff (sys_rst)
      (check_decided && rx_class == htd_cls_dma_setup)
      |-> link_fis_ok ##1 state_q == dma_setup_rx_state)
      else $error("dma setup frame not accepted");

   chk_bist_route: assert property (@(posedge clk) disable iff (sys_rst)
      (check_decided && rx_class == htd_cls_selftest)
      |-> link_fis_ok ##1 state_q == selftest_rx_state)
      else $error("selftest frame not accepted");

   cov_cmd_frame: cover property (@(posedge clk) disable iff (sys_rst)
      in_idle ##1 state_q == command_frame_tx_state);
   cov_pio_in: cover property (@(posedge clk) disable iff (sys_rst)
      state_q == pio_setup_rx_state ##[1:20] state_q == pio_data_in_state);
   cov_pio_out: cover property (@(posedge clk) disable iff (sys_rst)
      in_idle ##1 state_q == pio_data_out_state);
   cov_unknown: cover property (@(posedge clk) disable iff (sys_rst)
      link_fis_bad);

endmodule : htd_dispatch

/* logic/htd_type_decode.sv */
// classifier for the type byte of an incoming frame
`timescale 1ns/100ps
module htd_type_decode
   import htd_pkg::*;
(
   input wire logic [7:0] fis_type,
   output htd_pkg::htd_class_t fis_class
);
   always_comb
   begin
      unique case (fis_type)
         HTD_TYPE_REG_D2H,
         HTD_TYPE_REG_H2D: fis_class = htd_cls_register;
         HTD_TYPE_DEV_BITS: fis_class = htd_cls_dev_bits;
         HTD_TYPE_DMA_ACT: fis_class = htd_cls_dma_act;
         HTD_TYPE_PIO_SETUP: fis_class = htd_cls_pio_setup;
         HTD_TYPE_DMA_SETUP: fis_class = htd_cls_dma_setup;
         HTD_TYPE_SELFTEST: fis_class = htd_cls_selftest;
         HTD_TYPE_DATA: fis_class = htd_cls_data;
         // anything else, including unsupported codes
         default: fis_class = htd_cls_unknown;
      endcase
   end
endmodule : htd_type_decode

/* tb/htd_link_model.sv */
// link layer stand-in that presents incoming frame types
`timescale 1ns/100ps
module htd_link_model
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [1:0] dly,
   input wire logic [7:0] type_in,
   output logic link_rx_frame,
   output logic link_type_valid,
   output logic [7:0] link_rx_type
);
   logic [1:0] cnt_q;
   logic wait_q;
   logic [7:0] type_q;
   // released type lines show the inverse so a stale byte never matches
   assign link_rx_type = link_type_valid ? type_q : ~type_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         link_rx_frame <= 1'b0;
         link_type_valid <= 1'b0;
         wait_q <= 1'b0;
         cnt_q <= 2'h0;
         type_q <= 8'h00;
      end
      else if (start)
      begin
         link_rx_frame <= 1'b1;
         cnt_q <= dly;
         type_q <= type_in;
      end
      else if (link_rx_frame || wait_q)
      begin
         // slow link: type byte shows up dly cycles late
         link_rx_frame <= 1'b0;
         wait_q <= (cnt_q != 2'h0);
         link_type_valid <= (cnt_q == 2'h0);
         cnt_q <= cnt_q - 2'h1;
      end
      else
         link_type_valid <= 1'b0;
   end
endmodule : htd_link_model

/* tb/tb_top.sv */
// self-checking bench for the host transport dispatcher
`timescale 1ns/100ps
module tb_top;
   import htd_pkg::*;
   logic clk, sys_rst, cmd_wr, devctl_wr, link_illegal, app_dma_setup_req;
   logic app_selftest_req, app_data_wr, app_data_stall, handler_done;
   logic link_rx_frame, link_type_valid, f_start, pio_m, fire;
   logic link_fis_ok, link_fis_bad, tx_throttle, pio_setup_last;
   logic [7:0] devctl_wdata, link_rx_type, f_type, devctl_value, dv_m, v;
   logic [1:0] f_dly;
   logic [31:0] rnd;
   htd_trig_t ctl_trigger_mode;
   htd_state_t state;
   int fail_count, checks_done, cyc;
   logic [7:0] ftab [10] = '{HTD_TYPE_REG_D2H, HTD_TYPE_REG_H2D,
      HTD_TYPE_DEV_BITS, HTD_TYPE_DMA_ACT, HTD_TYPE_PIO_SETUP, HTD_TYPE_DATA,
      HTD_TYPE_DMA_SETUP, HTD_TYPE_SELFTEST, HTD_TYPE_DATA, 8'h00};

   htd_dispatch u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr),
      .devctl_wr(devctl_wr), .devctl_wdata(devctl_wdata),
      .ctl_trigger_mode(ctl_trigger_mode), .link_rx_frame(link_rx_frame),
      .link_type_valid(link_type_valid), .link_rx_type(link_rx_type),
      .link_illegal(link_illegal), .app_dma_setup_req(app_dma_setup_req),
      .app_selftest_req(app_selftest_req), .app_data_wr(app_data_wr),
      .app_data_stall(app_data_stall), .handler_done(handler_done),
      .state(state), .link_fis_ok(link_fis_ok), .link_fis_bad(link_fis_bad),
      .tx_throttle(tx_throttle), .pio_setup_last(pio_setup_last),
      .devctl_value(devctl_value));
   htd_link_model u_link (.clk(clk), .sys_rst(sys_rst), .start(f_start),
      .dly(f_dly), .type_in(f_type), .link_rx_frame(link_rx_frame),
      .link_type_valid(link_type_valid), .link_rx_type(link_rx_type));

   always #50 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   function automatic htd_state_t exp_st(input logic [7:0] t, input logic p);
      case (t)
         HTD_TYPE_REG_D2H, HTD_TYPE_REG_H2D: return register_frame_rx_state;
         HTD_TYPE_DEV_BITS: return device_bits_rx_state;
         HTD_TYPE_DMA_ACT: return dma_activate_rx_state;
         HTD_TYPE_PIO_SETUP: return pio_setup_rx_state;
         HTD_TYPE_DMA_SETUP: return dma_setup_rx_state;
         HTD_TYPE_SELFTEST: return selftest_rx_state;
         HTD_TYPE_DATA: return p ? pio_data_in_state : dma_data_in_state;
         default: return transport_idle_state;
      endcase
   endfunction : exp_st

   task automatic check(input string n, input logic [7:0] e,
      input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : check

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   task automatic see(input htd_state_t e);
      @(posedge clk);
      @(negedge clk);
      check("state", {4'h0, e}, {4'h0, state});
   endtask : see

   task automatic wait_st(input htd_state_t e);
      int n;
      n = 0;
      while (state !== e && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      check("state", {4'h0, e}, {4'h0, state});
   endtask : wait_st

   task automatic finish_h;
      @(posedge clk);
      if (state inside {pio_data_in_state, pio_data_out_state})
         pio_m = 1'b0;
      handler_done <= 1'b1;
      @(posedge clk);
      handler_done <= 1'b0;
      @(negedge clk);
      check("state", 8'h00, {4'h0, state});
      check("pio_last", {7'h0, pio_m}, {7'h0, pio_setup_last});
   endtask : finish_h

   task automatic wr(input logic c, input logic d, input logic a,
      input logic [7:0] val);
      @(posedge clk);
      cmd_wr <= c;
      devctl_wr <= d;
      app_data_wr <= a;
      devctl_wdata <= val;
      @(posedge clk);
      cmd_wr <= 1'b0;
      devctl_wr <= 1'b0;
      app_data_wr <= 1'b0;
   endtask : wr

   task automatic start_frame(input logic [7:0] t, input logic [1:0] d,
      input logic both);
      @(posedge clk);
      f_type <= t;
      f_dly <= d;
      f_start <= 1'b1;
      cmd_wr <= both;
      devctl_wr <= both;
      @(posedge clk);
      f_start <= 1'b0;
      cmd_wr <= 1'b0;
      devctl_wr <= 1'b0;
   endtask : start_frame

   task automatic rx_frame(input logic [7:0] t, input logic [1:0] d,
      input logic both);
      htd_state_t e;
      int n;
      e = exp_st(t, pio_m);
      n = 0;
      start_frame(t, d, both);
      while (link_type_valid !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      check("state", 8'h01, {4'h0, state});
      check("fis_ok", {7'h0, e != 0}, {7'h0, link_fis_ok});
      check("fis_bad", {7'h0, e == 0}, {7'h0, link_fis_bad});
      see(e);
      if (t == HTD_TYPE_PIO_SETUP)
         pio_m = 1'b1;
      else if (e != transport_idle_state && t != HTD_TYPE_DATA)
         pio_m = 1'b0;
      if (e != transport_idle_state)
         finish_h;
   endtask : rx_frame

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         give_verdict;
      end
   end

   initial
   begin
      {clk, cmd_wr, devctl_wr, link_illegal, app_dma_setup_req} = '0;
      {app_selftest_req, app_data_wr, app_data_stall, handler_done} = '0;
      {f_start, pio_m, f_dly, f_type, devctl_wdata} = '0;
      sys_rst = 1'b1;
      ctl_trigger_mode = htd_trig_soft_reset_bit_change;
      fail_count = 0;
      checks_done = 0;
      cyc = 0;
      dv_m = HTD_DEVCTL_RESET;
      rnd = 32'h5306;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) see(transport_idle_state);
      check("devctl", HTD_DEVCTL_RESET, devctl_value);
      $display("test reset done");
      foreach (ftab[i]) rx_frame(ftab[i], 2'h0, 1'b0);
      repeat (30)
      begin
         rnd = lfsr(lfsr(lfsr(rnd)));
         rx_frame(rnd[8] ? ftab[rnd[3:0] % 10] : rnd[7:0], rnd[13:12], 1'b0);
      end
      $display("test frames done");
      start_frame(HTD_TYPE_DATA, 2'h3, 1'b0);
      see(rx_type_check_state);
      @(posedge clk);
      link_illegal <= 1'b1;
      @(posedge clk);
      link_illegal <= 1'b0;
      @(negedge clk);
      check("state", 8'h00, {4'h0, state});
      repeat (6) @(posedge clk);
      // an illegal notice also ends a handler state
      wr(1'b1, 1'b0, 1'b0, dv_m);
      see(command_frame_tx_state);
      @(posedge clk);
      link_illegal <= 1'b1;
      @(posedge clk);
      link_illegal <= 1'b0;
      @(negedge clk);
      check("state", 8'h00, {4'h0, state});
      $display("test illegal done");
      @(posedge clk);
      app_data_stall <= 1'b1;
      wr(1'b1, 1'b0, 1'b0, dv_m);
      see(command_frame_tx_state);
      check("throttle", 8'h00, {7'h0, tx_throttle});
      finish_h;
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk);
         ctl_trigger_mode <= htd_trig_t'(m);
         for (int k = 0; k < 4; k++)
         begin
            rnd = lfsr(rnd);
            v = (k == 0) ? dv_m : (k == 1) ? dv_m ^ 8'h04 :
               (k == 2) ? dv_m ^ 8'h01 : rnd[7:0];
            fire = (m == 1) || (m == 2 && v != dv_m) || (m != 1 && m != 2 &&
               v[HTD_SOFT_RESET_BIT] != dv_m[HTD_SOFT_RESET_BIT]);
            wr(1'b0, 1'b1, 1'b0, v);
            see(fire ? control_frame_tx_state : transport_idle_state);
            check("devctl", v, devctl_value);
            dv_m = v;
            if (fire)
               finish_h;
         end
      end
      $display("test writes done");
      @(posedge clk);
      app_dma_setup_req <= 1'b1;
      app_selftest_req <= 1'b1;
      wait_st(dma_setup_tx_state);
      @(posedge clk);
      app_dma_setup_req <= 1'b0;
      finish_h;
      wait_st(selftest_tx_state);
      @(posedge clk);
      app_selftest_req <= 1'b0;
      finish_h;
      rx_frame(HTD_TYPE_PIO_SETUP, 2'h1, 1'b0);
      wr(1'b0, 1'b0, 1'b1, dv_m);
      see(pio_data_out_state);
      check("throttle", 8'h01, {7'h0, tx_throttle});
      @(posedge clk);
      app_data_stall <= 1'b0;
      finish_h;
      $display("test requests done");
      @(posedge clk);
      ctl_trigger_mode <= htd_trig_every_write;
      rx_frame(HTD_TYPE_REG_D2H, 2'h0, 1'b1);
      see(control_frame_tx_state);
      finish_h;
      see(command_frame_tx_state);
      finish_h;
      wr(1'b0, 1'b0, 1'b1, dv_m);
      repeat (3) see(transport_idle_state);
      $display("test priority done");
      // mid-run reset must drop the data write still pending from above
      pio_m = 1'b0;
      dv_m = HTD_DEVCTL_RESET;
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      see(transport_idle_state);
      check("devctl", HTD_DEVCTL_RESET, devctl_value);
      check("pio_last", 8'h00, {7'h0, pio_setup_last});
      rx_frame(HTD_TYPE_PIO_SETUP, 2'h0, 1'b0);
      repeat (3) see(transport_idle_state);
      $display("test reset again done");
      give_verdict;
   end
endmodule : tb_top
